/* bench/cad_core_props.sv */
`timescale 1ns/1ps
// ==========================================================
// Port level properties of the core.
module cad_core_props (
	input wire core_clk,
	input wire rst_n,
	input wire clkEn,
	input wire [15:0] memAddr_q,
	input wire memRd_q,
	input wire [7:0] acc_q,
	input wire [7:0] idx_q,
	input wire [4:0] condFlags_q,
	input wire halted_q,
	input wire instrDone_q,
	input wire ctrlEvent_q,
	input wire [7:0] ctrlCode_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_newCycle;
		$changed(memAddr_q);
	endsequence
	sequence s_holdCycle;
		$stable(memAddr_q) && $stable(memRd_q);
	endsequence
	property p_addrHold;
		s_newCycle |=> s_holdCycle;
	endproperty
	a_addrHold: assert property (p_addrHold) else $error("Bus address moved mid cycle");
	property p_doneOnce;
		instrDone_q && clkEn |=> !instrDone_q;
	endproperty
	a_doneOnce: assert property (p_doneOnce) else $error("Commit pulse too long");
	property p_haltQuiet;
		halted_q && $past(halted_q) |-> !memRd_q;
	endproperty
	a_haltQuiet: assert property (p_haltQuiet) else $error("Read while halted");
	property p_eventCode;
		ctrlEvent_q |-> ctrlCode_q inside {8'h80, 8'h81, 8'h83, 8'h8E, 8'h8F};
	endproperty
	a_eventCode: assert property (p_eventCode) else $error("Bad control code");
	property p_haltCause;
		$rose(halted_q) |-> ctrlCode_q inside {8'h8E, 8'h8F};
	endproperty
	a_haltCause: assert property (p_haltCause) else $error("Halt without stop");
	property p_flagsAtCommit;
		$changed(condFlags_q) |-> instrDone_q;
	endproperty
	a_flagsAtCommit: assert property (p_flagsAtCommit) else $error("Flags moved early");
	property p_accAtCommit;
		$changed(acc_q) |-> instrDone_q;
	endproperty
	a_accAtCommit: assert property (p_accAtCommit) else $error("Acc moved early");
	property p_idxAtCommit;
		$changed(idx_q) |-> instrDone_q;
	endproperty
	a_idxAtCommit: assert property (p_idxAtCommit) else $error("Index moved early");
endmodule
bind cad_core cad_core_props cad_core_props_i (.core_clk(core_clk), .rst_n(rst_n),
	.clkEn(clkEn), .memAddr_q(memAddr_q), .memRd_q(memRd_q), .acc_q(acc_q), .idx_q(idx_q),
	.condFlags_q(condFlags_q), .halted_q(halted_q), .instrDone_q(instrDone_q),
	.ctrlEvent_q(ctrlEvent_q), .ctrlCode_q(ctrlCode_q));

/* bench/cad_mem_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Memory behind the core's bus, answering with no wait states.
module cad_mem_model (
	input wire core_clk,
	input wire [15:0] busAddr,
	input wire busRd,
	output wire [7:0] rdData
);
	reg [7:0] mem [0:65535];
	reg [7:0] lastQ = 8'h00;
	// An idle bus shows the inverse of the last byte, so a stale sample cannot match by luck.
	assign rdData = busRd ? mem[busAddr] : ~lastQ;
	always @(posedge core_clk) begin
		if (busRd) begin
			lastQ <= mem[busAddr];
		end
	end
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
// ==========================================================
// Program driven check of the core.
module tb;
	reg core_clk = 1'b0;
	reg rst_n = 1'b0;
	reg clkEn = 1'b1;
	reg wakeUp = 1'b0;
	wire [7:0] memRdData;
	wire [15:0] memAddr_q;
	wire memRd_q;
	wire [7:0] acc_q;
	wire [7:0] idx_q;
	wire [15:0] pc_q;
	wire [7:0] sp_q;
	wire [4:0] condFlags_q;
	wire halted_q;
	wire instrDone_q;
	wire ctrlEvent_q;
	wire [7:0] ctrlCode_q;
	integer mismatches = 0;
	integer numChecks = 0;
	integer tick = 0;
	integer edges;
	integer i;
	reg [15:0] expPc = 16'h0100;
	reg [7:0] prog [0:58] = '{8'hAB, 8'h3C, 8'h99, 8'hA9, 8'hC4, 8'h97, 8'hB9, 8'h40,
		8'hC9, 8'h12, 8'h34, 8'hD9, 8'h20, 8'h00, 8'hE9, 8'h10, 8'hF9, 8'hBB, 8'h41,
		8'hCB, 8'h12, 8'h35, 8'hDB, 8'h20, 8'h01, 8'hEB, 8'h12, 8'hFB, 8'h99, 8'hA4,
		8'h0F, 8'hB4, 8'h42, 8'h9F, 8'hC4, 8'h12, 8'h36, 8'h98, 8'h9A, 8'h9B, 8'h9D,
		8'h9C, 8'hAB, 8'h7F, 8'h97, 8'h42, 8'h20, 8'h04, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'h01, 8'h40, 8'h02, 8'hFF, 8'hFF, 8'h8E, 8'h83};
	reg [23:0] data [0:11] = '{24'h00400E, 24'h123470, 24'h200180, 24'h001105, 24'h0001FA,
		24'h00419F, 24'h123561, 24'h20027F, 24'h001381, 24'h004205, 24'h123681, 24'h1FFC80};
	// Each entry: cycles, PC advance, accumulator, flags, index.
	reg [31:0] steps [0:29] = '{32'h223C0800, 32'h213C0900, 32'h22011900, 32'h21011901,
		32'h32101801, 32'h43800C01, 32'h53000B01, 32'h42060801, 32'h31001B01, 32'h329F0C01,
		32'h43001B01, 32'h537F0801, 32'h42001B01, 32'h31FA0C01, 32'h21FA0D01, 32'h220A0901,
		32'h32000B01, 32'h21010B01, 32'h43010901, 32'h21010801, 32'h21010001, 32'h21010801,
		32'h21010801, 32'h21010801, 32'h22801C01, 32'h21801C80, 32'hB1000C40, 32'h36000C40,
		32'h55000C40, 32'h21000C40};

	cad_core cad_core_i (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
		.memRdData(memRdData), .wakeUp(wakeUp), .memAddr_q(memAddr_q), .memRd_q(memRd_q),
		.acc_q(acc_q), .idx_q(idx_q), .pc_q(pc_q), .sp_q(sp_q), .condFlags_q(condFlags_q),
		.halted_q(halted_q), .instrDone_q(instrDone_q), .ctrlEvent_q(ctrlEvent_q),
		.ctrlCode_q(ctrlCode_q));
	cad_mem_model cad_mem_model_i (.core_clk(core_clk), .busAddr(memAddr_q), .busRd(memRd_q),
		.rdData(memRdData));

	always #50 core_clk = ~core_clk;

	// Gaps in the enable stretch some instructions, so cycle counts only count enabled edges.
	always @(posedge core_clk) begin
		#1 clkEn = (tick % 7) != 3;
		tick = tick + 1;
		if (tick >= 3000) begin
			mismatches = mismatches + 1;
			endSim();
		end
	end

	task chk(input [15:0] got, input [15:0] exp);
		begin
			numChecks = numChecks + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	task waitDone;
		reg en;
		integer n;
		begin
			edges = 0;
			for (n = 0; n < 400; n = n + 1) begin
				@(posedge core_clk);
				en = clkEn;
				edges = edges + en;
				#2;
				if (en && instrDone_q === 1'b1) break;
			end
			if (n == 400) mismatches = mismatches + 1;
		end
	endtask

	task step(input [31:0] e);
		begin
			waitDone();
			expPc = expPc + e[27:24];
			chk(edges[15:0], {11'h000, e[31:28], 1'b0});
			chk(pc_q, expPc);
			chk({8'h00, acc_q}, {8'h00, e[23:16]});
			chk({11'h000, condFlags_q}, {11'h000, e[12:8]});
			chk({8'h00, idx_q}, {8'h00, e[7:0]});
		end
	endtask

	task endSim;
		begin
			$display("Checks %0d, mismatches %0d", numChecks, mismatches);
			if (mismatches == 0 && numChecks > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask

	initial begin
		for (i = 0; i < 59; i = i + 1) cad_mem_model_i.mem[16'h0100 + i] = prog[i];
		for (i = 0; i < 12; i = i + 1) cad_mem_model_i.mem[data[i][23:8]] = data[i][7:0];
		cad_mem_model_i.mem[16'h1FFD] = 8'h27;
		cad_mem_model_i.mem[16'h1FFE] = 8'h02;
		cad_mem_model_i.mem[16'h1FFF] = 8'h81;
		repeat (4) @(posedge core_clk);
		#1 rst_n = 1'b1;
		for (i = 0; i < 30; i = i + 1) step(steps[i]);
		chk({15'h0000, ctrlEvent_q}, 16'h0001);
		chk(sp_q, 16'h00FF);
		chk(ctrlCode_q, 16'h008E);
		for (i = 0; i < 50 && halted_q !== 1'b1; i = i + 1) begin
			@(posedge core_clk);
			#2;
		end
		chk(memRd_q, 16'h0000);
		chk({15'h0000, halted_q}, 16'h0001);
		chk(memAddr_q, 16'h013A);
		@(posedge core_clk);
		#1 wakeUp = 1'b1;
		for (i = 0; i < 50 && halted_q !== 1'b0; i = i + 1) begin
			@(posedge core_clk);
			#1;
		end
		wakeUp = 1'b0;
		chk({15'h0000, halted_q}, 16'h0000);
		waitDone();
		chk(pc_q, 16'h1FFC);
		chk(ctrlCode_q, 16'h0083);
		waitDone();
		chk(ctrlCode_q, 16'h0080);
		waitDone();
		chk(edges[15:0], 16'h0006);
		chk(pc_q, 16'h1FFF);
		waitDone();
		chk(ctrlCode_q, 16'h0081);
		chk(pc_q, 16'h2000);
		endSim();
	end
endmodule

/* rtl/cad_alu.v */
`timescale 1ns/1ps
`include "cad_consts.vh"
module cad_alu (
	input wire [1:0] opSel,
	input wire [7:0] accIn,
	input wire [7:0] memIn,
	input wire [7:0] idxIn,
	input wire carryIn,
	output reg [7:0] result,
	output reg [7:0] highByte,
	output reg halfOut,
	output reg carryOut,
	output reg updHalfCarry
);

	reg [4:0] lowSum;
	reg [8:0] fullSum;
	reg [15:0] product;

	// ==========================================================
	// Operation select
	always @* begin
		lowSum = {1'b0, accIn[3:0]} + {1'b0, memIn[3:0]};
		fullSum = {1'b0, accIn} + {1'b0, memIn};
		product = {8'h00, accIn} * {8'h00, idxIn};
		result = fullSum[7:0];
		highByte = idxIn;
		halfOut = lowSum[4];
		carryOut = fullSum[8];
		updHalfCarry = 1'b1;
		case (opSel)
			`CAD_SEL_ADC: begin
				lowSum = lowSum + {4'h0, carryIn};
				fullSum = fullSum + {8'h00, carryIn};
				result = fullSum[7:0];
				halfOut = lowSum[4];
				carryOut = fullSum[8];
			end
			`CAD_SEL_ADD: begin
				result = fullSum[7:0];
			end
			`CAD_SEL_AND: begin
				result = accIn & memIn;
				updHalfCarry = 1'b0;
			end
			`CAD_SEL_MULTIPLY: begin
				result = product[7:0];
				highByte = product[15:8];
				halfOut = 1'b0;
				carryOut = 1'b0;
			end
			default: begin
				result = fullSum[7:0];
			end
		endcase
	end

endmodule

/* rtl/cad_consts.vh */
`ifndef CAD_CONSTS_VH
`define CAD_CONSTS_VH

// ==========================================================
// Internal cycle timing
`define CAD_OSC_PER_CYC 2
`define CAD_PHASE_LAST 1'b1

// ==========================================================
// Arithmetic and logic opcodes: high nibble is the mode
`define CAD_ALU_ADC 4'h9
`define CAD_ALU_ADD 4'hB
`define CAD_ALU_AND 4'h4
`define CAD_HI_IMMEDIATE 4'hA
`define CAD_HI_DIR 4'hB
`define CAD_HI_EXTENDED 4'hC
`define CAD_HI_IDX_WORD 4'hD
`define CAD_HI_IDX_BYTE 4'hE

// ==========================================================
// Inherent control opcodes
`define CAD_OP_COPY_ACC_TO_INDEX 8'h97
`define CAD_OP_COPY_INDEX_TO_ACC 8'h9F
`define CAD_OP_SET_CARRY_FLAG 8'h99
`define CAD_OP_CLEAR_CARRY_FLAG 8'h98
`define CAD_OP_SET_IRQ_MASK 8'h9B
`define CAD_OP_CLEAR_IRQ_MASK 8'h9A
`define CAD_OP_SOFTWARE_TRAP 8'h83
`define CAD_OP_RETURN_SUB 8'h81
`define CAD_OP_RETURN_FROM_TRAP 8'h80
`define CAD_OP_STACK_POINTER_REINIT 8'h9C
`define CAD_OP_NO_OPERATION 8'h9D
`define CAD_OP_HALT_STOP 8'h8E
`define CAD_OP_HALT_WAIT 8'h8F
`define CAD_OP_UNSIGNED_MULTIPLY 8'h42

// ==========================================================
// Relative branch opcodes
`define CAD_OP_BR_ALWAYS 8'h20
`define CAD_OP_BR_HIGHER 8'h22
`define CAD_OP_BR_CARRY_CLR 8'h24
`define CAD_OP_BR_CARRY_SET 8'h25
`define CAD_OP_BR_NOT_EQUAL 8'h26
`define CAD_OP_BR_EQUAL 8'h27

// ==========================================================
// Addressing mode classes
`define CAD_M_IMMEDIATE 4'h0
`define CAD_M_DIR 4'h1
`define CAD_M_EXTENDED 4'h2
`define CAD_M_IDX_WORD 4'h3
`define CAD_M_IDX_BYTE 4'h4
`define CAD_M_IX 4'h5
`define CAD_M_INHERENT 4'h6
`define CAD_M_REL 4'h7
`define CAD_M_BTB 4'h8

// ==========================================================
// Cycle counts in internal cycles
`define CAD_CYC_IMMEDIATE 4'h2
`define CAD_CYC_DIR 4'h3
`define CAD_CYC_EXTENDED 4'h4
`define CAD_CYC_IDX_WORD 4'h5
`define CAD_CYC_IDX_BYTE 4'h4
`define CAD_CYC_IX 4'h3
`define CAD_CYC_INHERENT 4'h2
`define CAD_CYC_REL 4'h3
`define CAD_CYC_BTB 4'h5
`define CAD_CYC_MULTIPLY 4'hB

// ==========================================================
// Condition flag bit positions and reset values
`define CAD_FLAG_C 0
`define CAD_FLAG_Z 1
`define CAD_FLAG_N 2
`define CAD_FLAG_I 3
`define CAD_FLAG_H 4
`define CAD_FLAGS_RESET 5'h08
`define CAD_SP_RESET 8'hFF

// ==========================================================
// Unit operation selects
`define CAD_SEL_ADC 2'h0
`define CAD_SEL_ADD 2'h1
`define CAD_SEL_AND 2'h2
`define CAD_SEL_MULTIPLY 2'h3

`endif

/* rtl/cad_core.v */
// What this block does
// - One internal cycle lasts exactly two enabled core clock cycles.
// - Control instructions are inherent only and fetch no operand bytes.
// - Copy accumulator into index register.
// - Copy index register into accumulator.
// - Add-with-carry loads accumulator with accumulator plus operand plus carry.
// - Add loads accumulator with accumulator plus operand.
// - AND loads accumulator with bitwise AND of accumulator and operand.
// - Cycle counts 2 immediate, 3 direct, 4 extended, 5/4/3 indexed.
// - Additions update H N Z C, keep I; AND updates only N and Z.
// - Direct mode fetches one byte as a low page address.
// - Extended mode fetches high then low address byte.
// - Word offset indexed fetches high then low offset, added to index.
// - Byte offset indexed fetches one offset byte added to index.
// - Immediate mode uses the following byte as the operand value.
// - Bit test branch fetches a direct address byte then a signed offset.
// - Relative mode fetches one offset byte as the branch displacement.
// - Multiply puts high product byte in index, low byte in accumulator.
`timescale 1ns/1ps
`include "cad_consts.vh"
module cad_core #(
	parameter [15:0] RESET_PC = 16'h0100,
	parameter [15:0] TRAP_PC = 16'h1FFC
) (
	input wire core_clk,
	input wire rst_n,
	input wire clkEn,
	input wire [7:0] memRdData,
	input wire wakeUp,
	output reg [15:0] memAddr_q,
	output reg memRd_q,
	output reg [7:0] acc_q,
	output reg [7:0] idx_q,
	output reg [15:0] pc_q,
	output reg [7:0] sp_q,
	output reg [4:0] condFlags_q,
	output reg halted_q,
	output reg instrDone_q,
	output reg ctrlEvent_q,
	output reg [7:0] ctrlCode_q
);

	// ==========================================================
	// Sequencer states
	localparam [2:0] S_OPC = 3'h0;
	localparam [2:0] S_B1 = 3'h1;
	localparam [2:0] S_B2 = 3'h2;
	localparam [2:0] S_IDX = 3'h3;
	localparam [2:0] S_RD = 3'h4;
	localparam [2:0] S_WAIT = 3'h5;
	localparam [2:0] S_HALT = 3'h6;

	// ==========================================================
	// Decode functions
	function [3:0] modeOf;
		input [7:0] opIn;
		begin
			if (opIn[7:4] >= `CAD_HI_IMMEDIATE && (opIn[3:0] == `CAD_ALU_ADC ||
				opIn[3:0] == `CAD_ALU_ADD || opIn[3:0] == `CAD_ALU_AND)) begin
				case (opIn[7:4])
					`CAD_HI_IMMEDIATE: modeOf = `CAD_M_IMMEDIATE;
					`CAD_HI_DIR: modeOf = `CAD_M_DIR;
					`CAD_HI_EXTENDED: modeOf = `CAD_M_EXTENDED;
					`CAD_HI_IDX_WORD: modeOf = `CAD_M_IDX_WORD;
					`CAD_HI_IDX_BYTE: modeOf = `CAD_M_IDX_BYTE;
					default: modeOf = `CAD_M_IX;
				endcase
			end else if (opIn[7:4] == 4'h0) begin
				modeOf = `CAD_M_BTB;
			end else if (opIn == `CAD_OP_BR_ALWAYS || opIn == `CAD_OP_BR_HIGHER ||
				(opIn >= `CAD_OP_BR_CARRY_CLR && opIn <= `CAD_OP_BR_EQUAL)) begin
				modeOf = `CAD_M_REL;
			end else begin
				modeOf = `CAD_M_INHERENT;
			end
		end
	endfunction

	function [3:0] cycOf;
		input [3:0] mdIn;
		input [7:0] opIn;
		begin
			case (mdIn)
				`CAD_M_IMMEDIATE: cycOf = `CAD_CYC_IMMEDIATE;
				`CAD_M_DIR: cycOf = `CAD_CYC_DIR;
				`CAD_M_EXTENDED: cycOf = `CAD_CYC_EXTENDED;
				`CAD_M_IDX_WORD: cycOf = `CAD_CYC_IDX_WORD;
				`CAD_M_IDX_BYTE: cycOf = `CAD_CYC_IDX_BYTE;
				`CAD_M_IX: cycOf = `CAD_CYC_IX;
				`CAD_M_REL: cycOf = `CAD_CYC_REL;
				`CAD_M_BTB: cycOf = `CAD_CYC_BTB;
				default: cycOf = (opIn == `CAD_OP_UNSIGNED_MULTIPLY) ?
					`CAD_CYC_MULTIPLY : `CAD_CYC_INHERENT;
			endcase
		end
	endfunction

	function relTaken;
		input [7:0] opIn;
		input [4:0] f;
		begin
			case (opIn)
				`CAD_OP_BR_ALWAYS: relTaken = 1'b1;
				`CAD_OP_BR_HIGHER: relTaken = ~(f[`CAD_FLAG_C] | f[`CAD_FLAG_Z]);
				`CAD_OP_BR_CARRY_CLR: relTaken = ~f[`CAD_FLAG_C];
				`CAD_OP_BR_CARRY_SET: relTaken = f[`CAD_FLAG_C];
				`CAD_OP_BR_NOT_EQUAL: relTaken = ~f[`CAD_FLAG_Z];
				`CAD_OP_BR_EQUAL: relTaken = f[`CAD_FLAG_Z];
				default: relTaken = 1'b0;
			endcase
		end
	endfunction

	// ==========================================================
	// Internal state
	reg phase_q;
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [3:0] cnt_q;
	reg [7:0] opc_q;
	reg [7:0] byte1_q;
	reg [7:0] byte1_d;
	reg [7:0] byte2_q;
	reg [7:0] byte2_d;
	reg [7:0] data_q;
	reg [15:0] ea_q;
	reg [15:0] ea_d;
	reg [15:0] pc_d;
	reg [7:0] acc_d;
	reg [7:0] idx_d;
	reg [7:0] sp_d;
	reg [4:0] flags_d;
	reg halt_d;
	reg event_d;
	reg wakeS1_q;
	reg wakeS2_q;
	reg [7:0] op;
	reg [3:0] md;
	reg commit;
	reg [1:0] aluSel;
	reg testBit;
	wire cycEnd;
	wire [7:0] aluRes;
	wire [7:0] aluHigh;
	wire aluHalf;
	wire aluCarry;
	wire aluUpdH;

	// An internal cycle closes on the second core clock of each pair.
	assign cycEnd = clkEn && (phase_q == `CAD_PHASE_LAST);

	cad_alu uAlu (
		.opSel(aluSel),
		.accIn(acc_q),
		.memIn(memRdData),
		.idxIn(idx_q),
		.carryIn(condFlags_q[`CAD_FLAG_C]),
		.result(aluRes),
		.highByte(aluHigh),
		.halfOut(aluHalf),
		.carryOut(aluCarry),
		.updHalfCarry(aluUpdH)
	);

	// ==========================================================
	// Sequencing and execution
	always @* begin
		op = (state_q == S_OPC) ? memRdData : opc_q;
		md = modeOf(op);
		commit = (state_q != S_OPC) && (state_q != S_HALT) && (cnt_q == cycOf(md, op) - 4'h1);
		case (op[3:0])
			`CAD_ALU_ADC: aluSel = `CAD_SEL_ADC;
			`CAD_ALU_ADD: aluSel = `CAD_SEL_ADD;
			`CAD_ALU_AND: aluSel = `CAD_SEL_AND;
			default: aluSel = `CAD_SEL_MULTIPLY;
		endcase
		testBit = data_q[op[3:1]];
		state_d = state_q;
		byte1_d = byte1_q;
		byte2_d = byte2_q;
		ea_d = ea_q;
		pc_d = pc_q;
		acc_d = acc_q;
		idx_d = idx_q;
		sp_d = sp_q;
		flags_d = condFlags_q;
		halt_d = 1'b0;
		event_d = 1'b0;
		case (state_q)
			S_OPC: begin
				pc_d = pc_q + 16'h0001;
				if (md == `CAD_M_INHERENT) begin
					state_d = S_WAIT;
				end else if (md == `CAD_M_IX) begin
					state_d = S_IDX;
				end else begin
					state_d = S_B1;
				end
			end
			S_B1: begin
				pc_d = pc_q + 16'h0001;
				byte1_d = memRdData;
				ea_d = {8'h00, memRdData};
				case (md)
					`CAD_M_DIR: state_d = S_RD;
					`CAD_M_BTB: state_d = S_RD;
					`CAD_M_EXTENDED: state_d = S_B2;
					`CAD_M_IDX_WORD: state_d = S_B2;
					`CAD_M_IDX_BYTE: state_d = S_IDX;
					default: state_d = S_WAIT;
				endcase
			end
			S_B2: begin
				pc_d = pc_q + 16'h0001;
				byte2_d = memRdData;
				if (md == `CAD_M_EXTENDED) begin
					ea_d = {byte1_q, memRdData};
					state_d = S_RD;
				end else if (md == `CAD_M_IDX_WORD) begin
					state_d = S_IDX;
				end else begin
					state_d = S_WAIT;
				end
			end
			S_IDX: begin
				if (md == `CAD_M_IDX_WORD) begin
					ea_d = {byte1_q, byte2_q} + {8'h00, idx_q};
				end else if (md == `CAD_M_IDX_BYTE) begin
					ea_d = {8'h00, byte1_q} + {8'h00, idx_q};
				end else begin
					ea_d = {8'h00, idx_q};
				end
				state_d = S_RD;
			end
			S_RD: begin
				state_d = S_B2;
			end
			S_HALT: begin
				if (wakeS2_q) begin
					state_d = S_OPC;
				end
			end
			default: begin
				state_d = S_WAIT;
			end
		endcase
		if (commit) begin
			state_d = S_OPC;
			if (md <= `CAD_M_IX) begin
				// The operand is the byte on the bus in the closing cycle.
				acc_d = aluRes;
				flags_d[`CAD_FLAG_N] = aluRes[7];
				flags_d[`CAD_FLAG_Z] = (aluRes == 8'h00);
				if (aluUpdH) begin
					flags_d[`CAD_FLAG_H] = aluHalf;
					flags_d[`CAD_FLAG_C] = aluCarry;
				end
			end else if (md == `CAD_M_REL) begin
				if (relTaken(op, condFlags_q)) begin
					pc_d = pc_q + {{8{byte1_q[7]}}, byte1_q};
				end
			end else if (md == `CAD_M_BTB) begin
				flags_d[`CAD_FLAG_C] = testBit;
				if (testBit != op[0]) begin
					pc_d = pc_q + {{8{byte2_q[7]}}, byte2_q};
				end
			end else begin
				case (op)
					`CAD_OP_COPY_ACC_TO_INDEX: idx_d = acc_q;
					`CAD_OP_COPY_INDEX_TO_ACC: acc_d = idx_q;
					`CAD_OP_SET_CARRY_FLAG: flags_d[`CAD_FLAG_C] = 1'b1;
					`CAD_OP_CLEAR_CARRY_FLAG: flags_d[`CAD_FLAG_C] = 1'b0;
					`CAD_OP_SET_IRQ_MASK: flags_d[`CAD_FLAG_I] = 1'b1;
					`CAD_OP_CLEAR_IRQ_MASK: flags_d[`CAD_FLAG_I] = 1'b0;
					`CAD_OP_STACK_POINTER_REINIT: sp_d = `CAD_SP_RESET;
					`CAD_OP_UNSIGNED_MULTIPLY: begin
						acc_d = aluRes;
						idx_d = aluHigh;
						flags_d[`CAD_FLAG_H] = 1'b0;
						flags_d[`CAD_FLAG_C] = 1'b0;
					end
					`CAD_OP_SOFTWARE_TRAP: begin
						flags_d[`CAD_FLAG_I] = 1'b1;
						pc_d = TRAP_PC;
						event_d = 1'b1;
					end
					`CAD_OP_RETURN_SUB: event_d = 1'b1;
					`CAD_OP_RETURN_FROM_TRAP: event_d = 1'b1;
					`CAD_OP_HALT_STOP: begin
						event_d = 1'b1;
						halt_d = 1'b1;
						state_d = S_HALT;
					end
					`CAD_OP_HALT_WAIT: begin
						event_d = 1'b1;
						halt_d = 1'b1;
						state_d = S_HALT;
					end
					default: acc_d = acc_q;
				endcase
			end
		end
	end

	// ==========================================================
	// Registers
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= 1'b0;
			state_q <= S_OPC;
			cnt_q <= 4'h0;
			opc_q <= 8'h00;
			byte1_q <= 8'h00;
			byte2_q <= 8'h00;
			data_q <= 8'h00;
			ea_q <= 16'h0000;
			wakeS1_q <= 1'b0;
			wakeS2_q <= 1'b0;
			memAddr_q <= RESET_PC;
			memRd_q <= 1'b1;
			acc_q <= 8'h00;
			idx_q <= 8'h00;
			pc_q <= RESET_PC;
			sp_q <= `CAD_SP_RESET;
			condFlags_q <= `CAD_FLAGS_RESET;
			halted_q <= 1'b0;
			instrDone_q <= 1'b0;
			ctrlEvent_q <= 1'b0;
			ctrlCode_q <= 8'h00;
		end else if (clkEn) begin
			wakeS1_q <= wakeUp;
			wakeS2_q <= wakeS1_q;
			phase_q <= ~phase_q;
			instrDone_q <= 1'b0;
			ctrlEvent_q <= 1'b0;
			if (cycEnd) begin
				state_q <= state_d;
				byte1_q <= byte1_d;
				byte2_q <= byte2_d;
				ea_q <= ea_d;
				pc_q <= pc_d;
				acc_q <= acc_d;
				idx_q <= idx_d;
				sp_q <= sp_d;
				condFlags_q <= flags_d;
				if (state_q == S_OPC) begin
					opc_q <= memRdData;
				end
				if (state_q == S_RD) begin
					data_q <= memRdData;
				end
				cnt_q <= (state_d == S_OPC || state_q == S_HALT) ? 4'h0 : cnt_q + 4'h1;
				memAddr_q <= (state_d == S_RD) ? ea_d : pc_d;
				memRd_q <= (state_d == S_OPC || state_d == S_B1 || state_d == S_B2 ||
					state_d == S_RD);
				instrDone_q <= commit;
				ctrlEvent_q <= event_d;
				if (event_d) begin
					ctrlCode_q <= op;
				end
				halted_q <= halt_d || (state_q == S_HALT && !wakeS2_q);
			end
		end
	end

endmodule
